// ### rtl/fpsf_pkg.sv
// package: constants and types of the flash programming command engine
package fpsf_pkg;
  // command bytes
  localparam logic [7:0] CMD_PREFIX   = 8'haa;
  localparam logic [7:0] OP_PROG_EN   = 8'hac;
  localparam logic [7:0] PROG_EN_KEY  = 8'h53;
  localparam logic [7:0] OP_RD_USER   = 8'h32;
  localparam logic [7:0] OP_RD_MAKER  = 8'h38;
  localparam logic [7:0] OP_LOAD_PAGE = 8'h51;
  localparam logic [7:0] OP_WR_USER   = 8'h52;
  localparam logic [7:0] OP_RD_LOCK   = 8'h64;
  localparam logic [7:0] OP_WR_LOCK   = 8'he4;
  localparam logic [7:0] OP_RD_FUSE   = 8'h61;
  localparam logic [7:0] OP_WR_FUSE   = 8'he1;
  localparam logic [7:0] OP_RD_STATUS = 8'h60;
  // fuse bit positions, each enable active low
  localparam int FUSE_ISP        = 0;
  localparam int FUSE_OSC_BYPASS = 1;
  localparam int FUSE_USER_ROW   = 2;
  localparam int FUSE_CLK_OUT    = 3;
  // lock bit positions, zero means locked
  localparam int LOCK_BIT1 = 0;
  localparam int LOCK_BIT2 = 1;
  // status byte layout
  localparam int STAT_BUSY    = 0;
  localparam int STAT_WRTBLK  = 1;
  localparam int STAT_SUCCESS = 2;
  localparam int STAT_LOAD    = 3;
  // page geometry and values after reset
  localparam int         PAGE_BYTES = 32;
  localparam int         ADDR_W     = 5;
  localparam logic [3:0] FUSE_RESET = 4'he;
  localparam logic [1:0] LOCK_RESET = 2'h3;
  localparam logic [7:0] SIG_BLANK  = 8'h00;
  // programming cycle time
  localparam int CLK_PERIOD_NS   = 25;
  localparam int PROG_TIME_US    = 2000;
  localparam int PROG_CYCLES_DEF = (PROG_TIME_US * 1000) / CLK_PERIOD_NS;
  localparam int CNT_W           = 20;
  // queued strobe item: bit 8 marks a falling edge, bits 7:0 the sampled byte
  localparam int ITEM_W    = 9;
  localparam int ITEM_FALL = 8;
  typedef enum logic [5:0] {
    ST_PREFIX = 6'h01,
    ST_OPCODE = 6'h02,
    ST_ARG1   = 6'h04,
    ST_ARG2   = 6'h08,
    ST_DATA   = 6'h10,
    ST_IGNORE = 6'h20
  } fpsf_state_t;
  typedef enum logic [1:0] {
    WR_NONE = 2'h0,
    WR_USER = 2'h1,
    WR_FUSE = 2'h2,
    WR_LOCK = 2'h3
  } fpsf_wkind_t;
endpackage

// ### rtl/fpsf_item_if.sv
// interface: valid/ready item stream between the strobe sampler, buffer and engine
`timescale 1ns/100ps
`default_nettype none
interface fpsf_item_if #(parameter int W = 9);
  logic         valid;
  logic         ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

// ### rtl/fpsf_pair_buf.sv
// module: small fifo with valid/ready on both sides, two entries by default
`timescale 1ns/100ps
`default_nettype none
module fpsf_pair_buf
  import fpsf_pkg::*;
#(
  parameter int WIDTH = ITEM_W,
  parameter int DEPTH = 2
) (
  input wire logic     sys_clk,
  input wire logic     reset,
  fpsf_item_if.snk     fill,
  fpsf_item_if.src     drain
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [PW-1:0] LAST = PW'(DEPTH - 1);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0]               wp;
    logic [PW-1:0]               rp;
    logic [PW:0]                 cnt;
  } fpsf_buf_state_t;

  fpsf_buf_state_t s;
  fpsf_buf_state_t next_s;
  logic            push;
  logic            pop;

  // full and empty come straight from the count
  assign fill.ready  = (s.cnt != (PW+1)'(DEPTH));
  assign drain.valid = (s.cnt != '0);
  assign drain.data  = s.mem[s.rp];
  assign push        = fill.valid && fill.ready;
  assign pop         = drain.valid && drain.ready;

  // pointer wrap is explicit so depths other than a power of two work
  always_comb begin
    next_s = s;
    if (push) begin
      next_s.mem[s.wp] = fill.data;
      next_s.wp        = (s.wp == LAST) ? '0 : s.wp + 1'b1;
    end
    if (pop) begin
      next_s.rp = (s.rp == LAST) ? '0 : s.rp + 1'b1;
    end
    next_s.cnt = s.cnt + (PW+1)'(push) - (PW+1)'(pop);
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end
endmodule
`default_nettype wire

// ### rtl/fpsf_prog_engine.sv
// module: parallel programming command engine with signature, fuse, lock and status
//
// Notes on behaviour
// [RULE_01] user signature read: prefix, opcode 32h, don't care, address, then data out
// [RULE_02] maker signature read: prefix, opcode 38h, don't care, address, then data out
// [RULE_03] program enable must come first; nothing else is accepted before it
// [RULE_04] one to 32 data bytes per command, address advances after each byte
// [RULE_05] fuse bits 0..3: serial prog, osc bypass, user row, clock out; zero enables
// [RULE_06] serial entry refused while the serial fuse is disabled
// [RULE_07] disabling that fuse mid-session keeps the session until session reset
// [RULE_08] lock bit one in bit 0, lock bit two in bit 1; zero is locked
// [RULE_09] maker page gives maker, part and filler bytes at addresses 0 to 2
// [RULE_10] status: bit 3 loaded, bit 2 success, bit 1 write blocked, bit 0 busy
// [RULE_11] load buffer clears the loaded flag; next memory write sets it again
// [RULE_12] success cleared at cycle start, set only if cycle saw no supply drop
// [RULE_13] write blocked flag is low while the supply monitor inhibits writes
// [RULE_14] a supply drop during a cycle leaves success low after the cycle
// [RULE_15] write blocked low forces busy low
// [RULE_16] busy is low during every programming cycle and while writes are inhibited
// [RULE_17] reading the last written byte mid-cycle returns it with msb inverted
// [RULE_18] select held low per command; bytes taken on the strobe's rising edge
// [RULE_19] busy returns high once the cycle ends unless writes are inhibited
`timescale 1ns/100ps
`default_nettype none
module fpsf_prog_engine
  import fpsf_pkg::*;
#(
  parameter int         PROG_CYCLES = PROG_CYCLES_DEF,
  parameter logic [7:0] MAKER_ID    = 8'h5a,  // arbitrary value
  parameter logic [7:0] PART_ID     = 8'h3c,  // arbitrary value
  parameter logic [7:0] FILLER_ID   = 8'ha5   // arbitrary value
) (
  input  wire logic       sys_clk,
  input  wire logic       reset,
  input  wire logic       session_active,
  input  wire logic       serial_session,
  input  wire logic       select_n,
  input  wire logic       byte_strobe_pin,
  input  wire logic [7:0] command_bus_port_in,
  output logic      [7:0] command_bus_port_out,
  output logic            command_bus_port_oe_n,
  input  wire logic       supply_drop_monitor,
  output logic            ready_not_busy,
  output logic      [7:0] programming_status,
  output logic      [3:0] fuse_settings,
  output logic      [1:0] lock_settings
);
  typedef struct packed {
    fpsf_state_t                          st;
    logic [7:0]                           opcode;
    logic [ADDR_W-1:0]                    addr;
    logic                                 enabled;
    logic                                 hold;
    logic                                 strobe_q;
    logic                                 pend_valid;
    logic [ITEM_W-1:0]                    pend_item;
    logic [7:0]                           bus_out;
    logic                                 bus_drive;
    logic [PAGE_BYTES-1:0][7:0]           user_row;
    logic [PAGE_BYTES-1:0][7:0]           pbuf;
    logic [PAGE_BYTES-1:0]                pmask;
    logic [ADDR_W-1:0]                    last_addr;
    fpsf_wkind_t                          wkind;
    logic [3:0]                           new_fuse;
    logic [1:0]                           new_lock;
    logic                                 cyc_run;
    logic [CNT_W-1:0]                     cyc_cnt;
    logic                                 drop_seen;
    logic                                 inhibit;
    logic                                 load_flag;
    logic                                 success_flag;
    logic [3:0]                           fuse;
    logic [1:0]                           lock;
  } fpsf_eng_state_t;

  fpsf_eng_state_t s;
  fpsf_eng_state_t next_s;

  fpsf_item_if #(.W(ITEM_W)) push_if ();
  fpsf_item_if #(.W(ITEM_W)) pop_if ();

  logic        busy_bit;
  logic [7:0]  status;
  logic [7:0]  rd_byte;
  logic [7:0]  row_at_addr;
  logic        rise_take;
  logic        fall_take;
  logic [7:0]  item_byte;
  logic        cs_release;

  // commands that fill the page buffer or schedule a write
  function automatic logic is_write_op(input logic [7:0] op);
    return (op == OP_LOAD_PAGE) || (op == OP_WR_USER) ||
           (op == OP_WR_FUSE) || (op == OP_WR_LOCK);
  endfunction

  function automatic logic is_read_op(input logic [7:0] op);
    return (op == OP_RD_USER) || (op == OP_RD_MAKER) || (op == OP_RD_LOCK) ||
           (op == OP_RD_FUSE) || (op == OP_RD_STATUS);
  endfunction

  // status byte; blocked writes also pull busy low
  assign busy_bit = !(s.cyc_run || s.inhibit);  // [RULE_15] [RULE_16] [RULE_19]
  assign status   = {4'h0, s.load_flag, s.success_flag, !s.inhibit, busy_bit};  // [RULE_10] [RULE_13]

  // buffer between the strobe sampler and the command decoder
  fpsf_pair_buf #(
    .WIDTH (ITEM_W),
    .DEPTH (2)
  ) u_buf (
    .sys_clk (sys_clk),
    .reset   (reset),
    .fill    (push_if),
    .drain   (pop_if)
  );

  assign push_if.valid = s.pend_valid;
  assign push_if.data  = s.pend_item;
  // decoder stalls one cycle after each stored byte, so the buffer can fill
  assign pop_if.ready  = !s.hold;
  assign rise_take     = pop_if.valid && pop_if.ready && !pop_if.data[ITEM_FALL];
  assign fall_take     = pop_if.valid && pop_if.ready && pop_if.data[ITEM_FALL];
  assign item_byte     = pop_if.data[7:0];
  // select release waits until every queued edge has been decoded
  assign cs_release    = select_n && !pop_if.valid && !s.pend_valid;
  assign row_at_addr   = s.user_row[s.addr];

  // byte returned for the current read opcode and address
  always_comb begin
    rd_byte = SIG_BLANK;
    if (s.opcode == OP_RD_USER) begin
      rd_byte = row_at_addr;  // [RULE_01]
      // polling shows the pending byte, not the old row content
      if (s.cyc_run && (s.wkind == WR_USER) && (s.addr == s.last_addr)) begin
        rd_byte = {!s.pbuf[s.last_addr][7], s.pbuf[s.last_addr][6:0]};  // [RULE_17]
      end
    end else if (s.opcode == OP_RD_MAKER) begin
      unique case (s.addr)  // [RULE_02] [RULE_09]
        5'h00:   rd_byte = MAKER_ID;
        5'h01:   rd_byte = PART_ID;
        5'h02:   rd_byte = FILLER_ID;
        default: rd_byte = SIG_BLANK;
      endcase
    end else if (s.opcode == OP_RD_FUSE) begin
      rd_byte = {4'h0, s.fuse};  // [RULE_05]
    end else if (s.opcode == OP_RD_LOCK) begin
      rd_byte = {6'h00, s.lock};  // [RULE_08]
    end else if (s.opcode == OP_RD_STATUS) begin
      rd_byte = status;
    end
  end

  // next-state logic for the whole engine
  always_comb begin
    next_s          = s;
    next_s.hold     = 1'b0;
    next_s.strobe_q = byte_strobe_pin;
    next_s.inhibit  = supply_drop_monitor;

    // strobe edges are queued in order; a rise carries the bus byte
    if (s.pend_valid && push_if.ready) begin
      next_s.pend_valid = 1'b0;
    end
    if (!select_n && (byte_strobe_pin != s.strobe_q)) begin
      next_s.pend_valid = 1'b1;
      next_s.pend_item  = byte_strobe_pin ? {1'b0, command_bus_port_in} :  // [RULE_18]
                                            {1'b1, 8'h00};
    end

    // decode of each queued edge
    if (rise_take) begin
      unique case (s.st)
        ST_PREFIX: begin
          next_s.st = (item_byte == CMD_PREFIX) ? ST_OPCODE : ST_IGNORE;
        end
        ST_OPCODE: begin
          next_s.opcode = item_byte;
          // a session accepts only the enable until it has seen one
          next_s.st = (!s.enabled && (item_byte != OP_PROG_EN)) ? ST_IGNORE : ST_ARG1;  // [RULE_03]
        end
        ST_ARG1: begin
          next_s.st = ST_ARG2;
          if (s.opcode == OP_PROG_EN) begin
            next_s.st = ST_IGNORE;
            // fuse checked only at entry, so a mid-session change has no effect
            if ((item_byte == PROG_EN_KEY) && !(serial_session && s.fuse[FUSE_ISP])) begin  // [RULE_06] [RULE_07]
              next_s.enabled = 1'b1;
            end
          end
        end
        ST_ARG2: begin
          next_s.addr = item_byte[ADDR_W-1:0];
          next_s.st   = ST_DATA;
          if (is_write_op(s.opcode) && s.cyc_run) begin
            next_s.st = ST_IGNORE;
          end else if (s.opcode == OP_LOAD_PAGE) begin
            next_s.load_flag = 1'b0;  // [RULE_11]
          end else if (s.opcode == OP_WR_USER) begin
            next_s.wkind = WR_USER;
          end else if (s.opcode == OP_WR_FUSE) begin
            next_s.wkind    = WR_FUSE;
            next_s.new_fuse = s.fuse;
          end else if (s.opcode == OP_WR_LOCK) begin
            next_s.wkind    = WR_LOCK;
            next_s.new_lock = s.lock;
          end else if (!is_read_op(s.opcode)) begin
            next_s.st = ST_IGNORE;
          end
        end
        ST_DATA: begin
          if ((s.opcode == OP_LOAD_PAGE) || (s.opcode == OP_WR_USER)) begin
            next_s.pbuf[s.addr]  = item_byte;
            next_s.pmask[s.addr] = 1'b1;
            next_s.last_addr     = s.addr;
            next_s.addr          = s.addr + 1'b1;  // [RULE_04]
            next_s.hold          = 1'b1;
          end else if (s.opcode == OP_WR_FUSE) begin
            next_s.new_fuse = item_byte[3:0];  // [RULE_05]
          end else if (s.opcode == OP_WR_LOCK) begin
            next_s.new_lock = item_byte[1:0];  // [RULE_08]
          end
        end
        ST_IGNORE: begin
          next_s.st = ST_IGNORE;
        end
      endcase
    end

    // read data leaves on each falling edge once the address byte is in
    if (fall_take && (s.st == ST_DATA) && is_read_op(s.opcode)) begin
      next_s.bus_out   = rd_byte;  // [RULE_01] [RULE_02]
      next_s.bus_drive = 1'b1;
      next_s.addr      = s.addr + 1'b1;  // [RULE_04]
    end

    // select high returns the interface to idle and launches a pending write
    if (cs_release) begin
      next_s.st        = ST_PREFIX;
      next_s.bus_drive = 1'b0;
      if ((s.wkind != WR_NONE) && !s.cyc_run) begin
        next_s.cyc_run      = 1'b1;
        next_s.cyc_cnt      = CNT_W'(PROG_CYCLES - 1);
        next_s.success_flag = 1'b0;  // [RULE_12]
        next_s.drop_seen    = s.inhibit;
      end
    end

    // programming cycle; any supply drop spoils it
    if (s.cyc_run) begin
      next_s.drop_seen = s.drop_seen || s.inhibit;  // [RULE_14]
      next_s.cyc_cnt   = s.cyc_cnt - 1'b1;
      if (s.cyc_cnt == '0) begin
        next_s.cyc_run      = 1'b0;
        next_s.success_flag = !(s.drop_seen || s.inhibit);  // [RULE_12] [RULE_14]
        next_s.load_flag    = 1'b1;  // [RULE_11]
        next_s.wkind        = WR_NONE;
        next_s.pmask        = '0;
        if (!(s.drop_seen || s.inhibit)) begin
          if ((s.wkind == WR_USER) && !s.fuse[FUSE_USER_ROW]) begin
            for (int i = 0; i < PAGE_BYTES; i++) begin
              if (s.pmask[i]) begin
                next_s.user_row[i] = s.pbuf[i];
              end
            end
          end
          if (s.wkind == WR_FUSE) begin
            next_s.fuse = s.new_fuse;
          end
          if (s.wkind == WR_LOCK) begin
            next_s.lock = s.new_lock;
          end
        end
      end
    end

    // end of session drops the enable and, unless a cycle is running, any unwritten buffer contents
    if (!session_active) begin
      next_s.enabled = 1'b0;  // [RULE_07]
      next_s.st      = ST_PREFIX;
      if (!s.cyc_run) begin
        next_s.pmask = '0;
        next_s.wkind = WR_NONE;
      end
    end
  end

  // one register bank for all engine state
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      s              <= '0;
      s.st           <= ST_PREFIX;
      s.wkind        <= WR_NONE;
      s.load_flag    <= 1'b1;
      s.success_flag <= 1'b1;
      s.fuse         <= FUSE_RESET;
      s.lock         <= LOCK_RESET;
    end else begin
      s <= next_s;
    end
  end

  assign command_bus_port_out  = s.bus_out;
  assign command_bus_port_oe_n = !s.bus_drive;
  assign ready_not_busy        = busy_bit;
  assign programming_status    = status;
  assign fuse_settings         = s.fuse;
  assign lock_settings         = s.lock;

  // checks on the engine's outputs and internal state
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  sequence seq_cycle_end;
    s.cyc_run ##1 !s.cyc_run;
  endsequence

  sequence seq_load_header;
    rise_take && (s.st == ST_ARG2) && (s.opcode == OP_LOAD_PAGE) && !s.cyc_run;
  endsequence

  busy_inhibit_a: assert property (s.inhibit |-> !programming_status[STAT_BUSY]) // [RULE_15]
    else $error("busy high while writes are inhibited");
  busy_cycle_a: assert property (s.cyc_run |-> !ready_not_busy) // [RULE_16]
    else $error("busy high during a programming cycle");
  busy_release_a: assert property (seq_cycle_end ##0 !s.inhibit |-> ready_not_busy) // [RULE_19]
    else $error("busy not released after the cycle");
  success_clear_a: assert property (s.cyc_run |-> !s.success_flag) // [RULE_12]
    else $error("success not cleared for the cycle");
  drop_fail_a: assert property (s.cyc_run && s.inhibit |=> !s.success_flag [*2]) // [RULE_14]
    else $error("success set after a supply drop");
  write_block_a: assert property (supply_drop_monitor |=> !programming_status[STAT_WRTBLK]) // [RULE_13]
    else $error("write blocked flag not low");
  load_clear_a: assert property (seq_load_header |=> !programming_status[STAT_LOAD]) // [RULE_11]
    else $error("loaded flag not cleared");
  enable_first_a: assert property (rise_take && (s.st == ST_OPCODE) && !s.enabled &&
      (item_byte != OP_PROG_EN) |=> (s.st == ST_IGNORE)) // [RULE_03]
    else $error("command accepted before program enable");
  addr_step_a: assert property (rise_take && (s.st == ST_DATA) && (s.opcode == OP_WR_USER)
      |=> (s.addr == $past(s.addr) + 5'h01) && s.pmask[$past(s.addr)]) // [RULE_04]
    else $error("address did not advance after a data byte");
  maker_sig_a: assert property (fall_take && (s.st == ST_DATA) && (s.opcode == OP_RD_MAKER) &&
      (s.addr == 5'h00) |=> (command_bus_port_out == MAKER_ID) && !command_bus_port_oe_n) // [RULE_09]
    else $error("maker byte not returned at address zero");
  poll_invert_a: assert property (fall_take && (s.st == ST_DATA) && (s.opcode == OP_RD_USER) &&
      s.cyc_run && (s.wkind == WR_USER) && (s.addr == s.last_addr)
      |=> command_bus_port_out == ($past(s.pbuf[s.last_addr]) ^ 8'h80)) // [RULE_17]
    else $error("polled byte msb not inverted");
  serial_refuse_a: assert property (rise_take && (s.st == ST_ARG1) && (s.opcode == OP_PROG_EN) &&
      serial_session && s.fuse[FUSE_ISP] && !s.enabled |=> !s.enabled) // [RULE_06]
    else $error("serial entry accepted with fuse disabled");
endmodule
`default_nettype wire

// ### test/fpsf_programmer.sv
// partner model: external programmer driving select, strobe and command bus
`timescale 1ns/100ps
`default_nettype none
module fpsf_programmer (
  input  wire logic       sys_clk,
  output logic            select_n,
  output logic            byte_strobe_pin,
  output logic      [7:0] bus_drive,
  output logic            bus_en
);
  initial begin
    select_n        = 1'b1;
    byte_strobe_pin = 1'b0;
    bus_drive       = 8'h00;
    bus_en          = 1'b0;
  end
  // select goes low well ahead of the first strobe
  task automatic open_cmd();
    @(negedge sys_clk);
    select_n = 1'b0;
    repeat (2) @(negedge sys_clk);
  endtask
  // one strobe pulse, byte taken on the rise; high 4 cycles and low 6 cycles, both longer than 3
  task automatic put(input logic [7:0] b, input logic drv);
    bus_drive       = b;
    bus_en          = drv;
    byte_strobe_pin = 1'b1;
    repeat (4) @(negedge sys_clk);
    bus_en          = 1'b0;  // let go before the fall, the device may answer
    byte_strobe_pin = 1'b0;
    repeat (6) @(negedge sys_clk);
  endtask
  // select high between commands resets the decoder
  task automatic close_cmd();
    bus_en   = 1'b0;
    select_n = 1'b1;
    repeat (4) @(negedge sys_clk);
  endtask
endmodule
`default_nettype wire

// ### test/test_flash_program_status_fuse_logic.sv
// testbench: programmer command sequences against the programming engine
`timescale 1ns/100ps
`default_nettype none
module test_flash_program_status_fuse_logic;
  import fpsf_pkg::*;
  localparam int         PC = 400;     // shortened cycle, leaves room to poll
  localparam logic [7:0] MK = 8'h6b;   // arbitrary value
  localparam logic [7:0] PT = 8'h29;   // arbitrary value
  localparam logic [7:0] FL = 8'hc4;   // arbitrary value
  logic       sys_clk             = 1'b0;
  logic       reset               = 1'b1;
  logic       session_active      = 1'b1;
  logic       serial_session      = 1'b0;
  logic       supply_drop_monitor = 1'b0;
  logic [7:0] bus;
  logic [7:0] bus_last            = 8'h00;
  wire logic       select_n;
  wire logic       byte_strobe_pin;
  wire logic       p_en;
  wire logic       oe_n;
  wire logic       ready_not_busy;
  wire logic [7:0] p_data;
  wire logic [7:0] dev_out;
  wire logic [7:0] programming_status;
  wire logic [3:0] fuse_settings;
  wire logic [1:0] lock_settings;
  int n_errors        = 0;
  int samples_checked = 0;

  always #12.5 sys_clk = ~sys_clk;
  // wire level; a released bus keeps changing so stale data cannot pass
  always_comb begin
    if (!oe_n) bus = dev_out;
    else if (p_en) bus = p_data;
    else bus = ~bus_last;
  end
  always @(posedge sys_clk) bus_last <= bus;

  fpsf_programmer fpsf_programmer_i (
    .sys_clk         (sys_clk),
    .select_n        (select_n),
    .byte_strobe_pin (byte_strobe_pin),
    .bus_drive       (p_data),
    .bus_en          (p_en)
  );
  fpsf_prog_engine #(.PROG_CYCLES(PC), .MAKER_ID(MK), .PART_ID(PT), .FILLER_ID(FL))
    fpsf_prog_engine_i (
    .sys_clk               (sys_clk),
    .reset                 (reset),
    .session_active        (session_active),
    .serial_session        (serial_session),
    .select_n              (select_n),
    .byte_strobe_pin       (byte_strobe_pin),
    .command_bus_port_in   (bus),
    .command_bus_port_out  (dev_out),
    .command_bus_port_oe_n (oe_n),
    .supply_drop_monitor   (supply_drop_monitor),
    .ready_not_busy        (ready_not_busy),
    .programming_status    (programming_status),
    .fuse_settings         (fuse_settings),
    .lock_settings         (lock_settings)
  );

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tally_and_finish();
    $display("mismatches %0d of %0d checks", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // bounded wait on the ready line; running out ends the run
  task automatic wait_rdy(input logic lvl, input int lim);
    int k = 0;
    while (ready_not_busy !== lvl && k < lim) begin
      @(negedge sys_clk);
      k++;
    end
    if (ready_not_busy !== lvl) begin
      check("ready wait", {7'h00, ready_not_busy}, {7'h00, lvl});
      tally_and_finish();
    end
  endtask
  task automatic cycle();
    wait_rdy(1'b0, 10);
    wait_rdy(1'b1, PC + 20);
  endtask
  // prefix, opcode, don't-care, address
  task automatic hdr(input logic [7:0] op, input logic [7:0] a);
    fpsf_programmer_i.open_cmd();
    fpsf_programmer_i.put(CMD_PREFIX, 1'b1);
    fpsf_programmer_i.put(op, 1'b1);
    fpsf_programmer_i.put(8'h00, 1'b1);
    fpsf_programmer_i.put(a, 1'b1);
  endtask
  task automatic wr(input logic [7:0] op, input logic [7:0] a, input logic [7:0] d[$]);
    hdr(op, a);
    foreach (d[i]) fpsf_programmer_i.put(d[i], 1'b1);
    fpsf_programmer_i.close_cmd();
  endtask
  // each byte is looked at late in the low phase, after the device answered
  task automatic rd(input string what, input logic [7:0] op, input logic [7:0] a,
                    input logic [7:0] e[$]);
    hdr(op, a);
    foreach (e[i]) begin
      check(what, bus, e[i]);
      if (i < e.size() - 1) fpsf_programmer_i.put(8'h00, 1'b0);
    end
    fpsf_programmer_i.close_cmd();
  endtask
  task automatic enable();
    fpsf_programmer_i.open_cmd();
    fpsf_programmer_i.put(CMD_PREFIX, 1'b1);
    fpsf_programmer_i.put(OP_PROG_EN, 1'b1);
    fpsf_programmer_i.put(PROG_EN_KEY, 1'b1);
    fpsf_programmer_i.close_cmd();
  endtask

  initial begin
    repeat (3) @(negedge sys_clk);
    reset = 1'b0;
    @(negedge sys_clk);
    check("status", programming_status, 8'h0f);
    check("fuse", {4'h0, fuse_settings}, 8'h0e);
    check("lock", {6'h00, lock_settings}, 8'h03);
    // a read before the enable must not drive the bus
    hdr(OP_RD_MAKER, 8'h00);
    check("oe_n early", {7'h00, oe_n}, 8'h01);
    fpsf_programmer_i.close_cmd();
    enable();
    rd("maker", OP_RD_MAKER, 8'h00, '{MK, PT, FL, 8'h00});
    // open user row programming, keep serial entry enabled
    wr(OP_WR_FUSE, 8'h00, '{8'h0a});
    cycle();
    check("fuse", {4'h0, fuse_settings}, 8'h0a);
    rd("fuse rd", OP_RD_FUSE, 8'h00, '{8'h0a});
    check("status", programming_status, 8'h0f);
    // preload the last page byte, then write byte 0 and read back across the wrap
    wr(OP_LOAD_PAGE, 8'h1f, '{8'h77});
    check("status", programming_status, 8'h07);
    wr(OP_WR_USER, 8'h00, '{8'h88});
    wait_rdy(1'b0, 10);
    check("status", programming_status, 8'h02);
    rd("poll", OP_RD_USER, 8'h00, '{8'h08});
    wait_rdy(1'b1, PC);
    check("status", programming_status, 8'h0f);
    rd("row", OP_RD_USER, 8'h1f, '{8'h77, 8'h88});
    // supply drop while idle
    supply_drop_monitor = 1'b1;
    repeat (3) @(negedge sys_clk);
    check("status", programming_status, 8'h0c);
    supply_drop_monitor = 1'b0;
    repeat (3) @(negedge sys_clk);
    check("status", programming_status, 8'h0f);
    // supply drop inside a lock write spoils the cycle
    wr(OP_WR_LOCK, 8'h00, '{8'h02});
    wait_rdy(1'b0, 10);
    supply_drop_monitor = 1'b1;
    repeat (5) @(negedge sys_clk);
    supply_drop_monitor = 1'b0;
    wait_rdy(1'b1, PC);
    check("status", programming_status, 8'h0b);
    check("lock", {6'h00, lock_settings}, 8'h03);
    wr(OP_WR_LOCK, 8'h00, '{8'h02});
    cycle();
    check("lock", {6'h00, lock_settings}, 8'h02);
    check("status", programming_status, 8'h0f);
    rd("lock rd", OP_RD_LOCK, 8'h00, '{8'h02});
    rd("status rd", OP_RD_STATUS, 8'h00, '{8'h0f});
    // serial session disables its own entry fuse and stays alive
    session_active = 1'b0;
    repeat (3) @(negedge sys_clk);
    serial_session = 1'b1;
    session_active = 1'b1;
    repeat (3) @(negedge sys_clk);
    enable();
    wr(OP_WR_FUSE, 8'h00, '{8'h0b});
    cycle();
    check("fuse", {4'h0, fuse_settings}, 8'h0b);
    rd("still on", OP_RD_MAKER, 8'h00, '{MK});
    // a fresh serial session is refused
    session_active = 1'b0;
    repeat (3) @(negedge sys_clk);
    session_active = 1'b1;
    repeat (3) @(negedge sys_clk);
    enable();
    hdr(OP_RD_MAKER, 8'h00);
    check("oe_n serial", {7'h00, oe_n}, 8'h01);
    fpsf_programmer_i.close_cmd();
    tally_and_finish();
  end
endmodule
`default_nettype wire
